// >>> src/i2c_tx_ctrl_pkg.sv
// shared constants and carriers for the i2c data-send controller
package i2c_tx_ctrl_pkg;

    // channel operation clock assumed for the divider limits
    localparam int unsigned OP_CLOCK_HZ = 25_000_000;
    localparam int unsigned FAST_MAX_HZ = 400_000;
    localparam int unsigned STD_MAX_HZ  = 100_000;

    // rate = clock / (div + 1) / 2, so div >= clock / (2 * limit) - 1
    localparam logic [6:0] DIV_MIN_FAST =
        7'((OP_CLOCK_HZ + 2 * FAST_MAX_HZ - 1) / (2 * FAST_MAX_HZ) - 1);
    localparam logic [6:0] DIV_MIN_STD  =
        7'((OP_CLOCK_HZ + 2 * STD_MAX_HZ - 1) / (2 * STD_MAX_HZ) - 1);
    localparam logic [6:0] DIV_FLOOR    = 7'h01;

    localparam int BYTE_W = 8;
    localparam int DIV_W  = 7;
    localparam int REG_W  = 16;

    // channel_mode_config: bit 5 set, mode 1,0,0, prescaler pick at 15
    localparam logic [15:0] MODE_FIXED = 16'h0024;
    localparam int          CKS_BIT    = 15;

    // channel_comm_setting: tx on, rx off, msb first, stop 01, 8 bits
    localparam logic [15:0] COMM_TX = 16'h8017;

    // status word read back from the device
    localparam int ACK_ERR_BIT = 1;

    // link-domain wait count, one less than the cycles from status read strobe to sampling the reply
    localparam logic [1:0] RD_WAIT = 2'h3;

    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = 9;

    typedef enum logic [2:0] {
        SEL_MODE,
        SEL_COMM,
        SEL_LEVELS,
        SEL_ENABLES,
        SEL_LAUNCH,
        SEL_DATA,
        SEL_STATUS
    } reg_sel_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        reg_sel_t    sel;
        logic [15:0] wdata;
    } reg_cmd_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } tx_byte_t;

    typedef struct packed {
        logic [6:0] divider;
        logic       prescaler;
        logic       fast;
    } xfer_cfg_t;

endpackage

// >>> src/i2c_tx_ctrl.sv
// host controller that feeds data bytes to the i2c channel
`timescale 1ns/100ps

module tx_byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        room;
        logic                        avail;
    } fifo_state_t;

    fifo_state_t q_reg;
    fifo_state_t q_next;
    logic        push;
    logic        pop;

    always_comb begin
        q_next = q_reg;
        push   = i_wr_valid & q_reg.room;
        pop    = i_rd_ready & q_reg.avail;
        if (push) begin
            q_next.mem[q_reg.wp] = i_wr_data;
            q_next.wp            = q_reg.wp + 1'b1;
        end
        if (pop) begin
            q_next.rp = q_reg.rp + 1'b1;
        end
        q_next.cnt   = q_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // ready is a flop, low in reset so no push is lost
        q_next.room  = (q_next.cnt != (AW+1)'(DEPTH));
        q_next.avail = (q_next.cnt != '0);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_wr_ready = q_reg.room;
    assign o_rd_valid = q_reg.avail;
    assign o_rd_data  = q_reg.mem[q_reg.rp];
endmodule // tx_byte_fifo

module i2c_tx_ctrl (
    input  wire logic                       i_clk,
    input  wire logic                       i_nrst,
    input  wire logic                       i_link_clk,
    input  wire i2c_tx_ctrl_pkg::xfer_cfg_t i_cfg,
    input  wire logic                       i_go,
    input  wire logic                       i_addr_sent,
    input  wire logic                       i_byte_valid,
    input  wire i2c_tx_ctrl_pkg::tx_byte_t  i_byte,
    output logic                            o_byte_ready,
    output logic                            o_busy,
    output logic                            o_done,
    output logic                            o_ack_err,
    output logic                            o_refused,
    output i2c_tx_ctrl_pkg::reg_cmd_t       o_reg,
    input  wire logic [15:0]                i_reg_rdata,
    input  wire logic                       i_xfer_end,
    output logic                            o_stop_req
);
    import i2c_tx_ctrl_pkg::*;

    typedef enum logic [3:0] {
        L_IDLE,
        L_MODE,
        L_COMM,
        L_ASK,
        L_WAIT_BYTE,
        L_WRITE,
        L_WAIT_END,
        L_READ,
        L_CHECK,
        L_STOP
    } link_state_t;

    typedef struct packed {
        logic            go_tgl;
        logic            busy;
        logic            pending;
        logic [2:0]      req_s;
        logic [2:0]      done_s;
        logic            reply_tgl;
        tx_byte_t        hold;
        xfer_cfg_t       cfg;
        logic            done;
        logic            ack_err;
        logic            refused;
    } sys_state_t;

    typedef struct packed {
        link_state_t     st;
        logic [2:0]      go_s;
        logic [2:0]      reply_s;
        logic [2:0]      irq_s;
        logic [1:0][15:0] rdata_s;
        logic [1:0]      wait_cnt;
        logic            req_tgl;
        logic            done_tgl;
        logic            ack_err;
        tx_byte_t        cur;
        reg_cmd_t        cmd;
        logic            stop;
    } link_state_reg_t;

    sys_state_t      s_reg;
    sys_state_t      s_next;
    link_state_reg_t l_reg;
    link_state_reg_t l_next;
    logic [1:0]      srst_reg;
    logic [1:0]      lrst_reg;
    logic            srst_n;
    logic            lrst_n;
    logic            fifo_ready;
    logic            fifo_valid;
    logic            fifo_pop;
    tx_byte_t        fifo_data;

    // toggle seen on the second and third flop of a synchroniser
    function automatic logic toggled(input logic [2:0] sync);
        return sync[2] ^ sync[1];
    endfunction

    function automatic logic [6:0] safe_div(input xfer_cfg_t cfg);
        logic [6:0] lim;
        lim = cfg.fast ? DIV_MIN_FAST : DIV_MIN_STD;
        if (lim < DIV_FLOOR) begin
            lim = DIV_FLOOR;
        end
        return (cfg.divider < lim) ? lim : cfg.divider;
    endfunction

    // reset release, one synchroniser per domain
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            srst_reg <= 2'h0;
        end else begin
            srst_reg <= {srst_reg[0], 1'b1};
        end
    end

    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lrst_reg <= 2'h0;
        end else begin
            lrst_reg <= {lrst_reg[0], 1'b1};
        end
    end

    assign srst_n = srst_reg[1];
    assign lrst_n = lrst_reg[1];

    tx_byte_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_rst_n    (srst_n),
        .i_wr_valid (i_byte_valid),
        .o_wr_ready (fifo_ready),
        .i_wr_data  (i_byte),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (fifo_pop),
        .o_rd_data  (fifo_data)
    );

    // a byte leaves the fifo only when the link has asked for one
    assign fifo_pop = s_reg.pending & fifo_valid;

    // user clock domain
    always_comb begin
        s_next         = s_reg;
        s_next.done    = 1'b0;
        s_next.refused = 1'b0;
        s_next.req_s   = {s_reg.req_s[1:0], l_reg.req_tgl};
        s_next.done_s  = {s_reg.done_s[1:0], l_reg.done_tgl};
        if (i_go && !s_reg.busy) begin
            if (i_addr_sent) begin
                s_next.busy    = 1'b1;
                s_next.cfg     = i_cfg;
                s_next.go_tgl  = ~s_reg.go_tgl;
                s_next.ack_err = 1'b0;
            end else begin
                s_next.refused = 1'b1;
            end
        end
        if (toggled(s_reg.req_s)) begin
            s_next.pending = 1'b1;
        end
        // empty fifo just stalls the link until the user refills it
        if (fifo_pop) begin
            s_next.pending   = 1'b0;
            s_next.hold      = fifo_data;
            s_next.reply_tgl = ~s_reg.reply_tgl;
        end
        if (toggled(s_reg.done_s)) begin
            // link is idle here, so its error flag is stable
            s_next.busy    = 1'b0;
            s_next.done    = 1'b1;
            s_next.pending = 1'b0;
            s_next.ack_err = l_reg.ack_err;
        end
    end

    always_ff @(posedge i_clk or negedge srst_n) begin
        if (!srst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // link clock domain
    always_comb begin
        l_next         = l_reg;
        l_next.cmd.wr  = 1'b0;
        l_next.cmd.rd  = 1'b0;
        l_next.stop    = 1'b0;
        l_next.go_s    = {l_reg.go_s[1:0], s_reg.go_tgl};
        l_next.reply_s = {l_reg.reply_s[1:0], s_reg.reply_tgl};
        l_next.irq_s   = {l_reg.irq_s[1:0], i_xfer_end};
        l_next.rdata_s = {l_reg.rdata_s[0], i_reg_rdata};
        unique case (l_reg.st)
            L_IDLE: begin
                if (toggled(l_reg.go_s)) begin
                    l_next.ack_err = 1'b0;
                    l_next.st      = L_MODE;
                end
            end
            L_MODE: begin
                l_next.cmd.wr    = 1'b1;
                l_next.cmd.sel   = SEL_MODE;
                l_next.cmd.wdata = MODE_FIXED |
                    (16'(s_reg.cfg.prescaler) << CKS_BIT);
                l_next.st        = L_COMM;
            end
            L_COMM: begin
                l_next.cmd.wr    = 1'b1;
                l_next.cmd.sel   = SEL_COMM;
                l_next.cmd.wdata = COMM_TX;
                l_next.st        = L_ASK;
            end
            L_ASK: begin
                l_next.req_tgl = ~l_reg.req_tgl;
                l_next.st      = L_WAIT_BYTE;
            end
            L_WAIT_BYTE: begin
                if (toggled(l_reg.reply_s)) begin
                    l_next.cur = s_reg.hold;
                    l_next.st  = L_WRITE;
                end
            end
            L_WRITE: begin
                l_next.cmd.wr    = 1'b1;
                l_next.cmd.sel   = SEL_DATA;
                l_next.cmd.wdata = {safe_div(s_reg.cfg), 1'b0,
                                    l_reg.cur.data};
                l_next.st        = L_WAIT_END;
            end
            L_WAIT_END: begin
                if (toggled(l_reg.irq_s)) begin
                    l_next.st = L_READ;
                end
            end
            L_READ: begin
                l_next.cmd.rd   = 1'b1;
                l_next.cmd.sel  = SEL_STATUS;
                l_next.wait_cnt = 2'h0;
                l_next.st       = L_CHECK;
            end
            L_CHECK: begin
                // reply crosses two flops, so sample a few edges late
                l_next.wait_cnt = l_reg.wait_cnt + 2'h1;
                if (l_reg.wait_cnt == RD_WAIT) begin
                    l_next.ack_err = l_reg.rdata_s[1][ACK_ERR_BIT];
                    if (l_reg.rdata_s[1][ACK_ERR_BIT] || l_reg.cur.last)
                    begin
                        l_next.st = L_STOP;
                    end else begin
                        l_next.st = L_ASK;
                    end
                end
            end
            L_STOP: begin
                l_next.stop     = 1'b1;
                l_next.done_tgl = ~l_reg.done_tgl;
                l_next.st       = L_IDLE;
            end
            default: begin
                l_next.st = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    assign o_byte_ready = fifo_ready;
    assign o_busy       = s_reg.busy;
    assign o_done       = s_reg.done;
    assign o_ack_err    = s_reg.ack_err;
    assign o_refused    = s_reg.refused;
    assign o_reg        = l_reg.cmd;
    assign o_stop_req   = l_reg.stop;
endmodule // i2c_tx_ctrl

// >>> testbench/i2c_tx_ctrl_sva.sv
// checker for the i2c data-send controller ports
`timescale 1ns/100ps
module i2c_tx_ctrl_sva
    import i2c_tx_ctrl_pkg::*;
(
    input wire logic                       i_clk,
    input wire logic                       i_nrst,
    input wire logic                       i_link_clk,
    input wire i2c_tx_ctrl_pkg::xfer_cfg_t i_cfg,
    input wire logic                       i_go,
    input wire logic                       i_addr_sent,
    input wire logic                       i_byte_valid,
    input wire i2c_tx_ctrl_pkg::tx_byte_t  i_byte,
    input wire logic                       o_byte_ready,
    input wire logic                       o_busy,
    input wire logic                       o_done,
    input wire logic                       o_ack_err,
    input wire logic                       o_refused,
    input wire i2c_tx_ctrl_pkg::reg_cmd_t  o_reg,
    input wire logic [15:0]                i_reg_rdata,
    input wire logic                       i_xfer_end,
    input wire logic                       o_stop_req
);
    a_go_refused: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_go && !o_busy && !i_addr_sent |=> o_refused && !o_busy)
        else $error("go without address not refused");
    a_go_starts: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_go && !o_busy && i_addr_sent |=> o_busy && !o_refused)
        else $error("accepted go did not raise busy");
    a_done_ends_busy: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        $fell(o_busy) |-> o_done ##1 !o_done)
        else $error("busy fell without one done pulse");
    a_write_sel_legal: assert property (
        @(posedge i_link_clk) disable iff (!i_nrst)
        o_reg.wr |-> o_reg.sel inside {SEL_MODE, SEL_COMM, SEL_DATA})
        else $error("write to a register locked mid-transfer");
    a_mode_word: assert property (
        @(posedge i_link_clk) disable iff (!i_nrst)
        o_reg.wr && o_reg.sel == SEL_MODE
            |-> (o_reg.wdata & 16'h7fff) == MODE_FIXED)
        else $error("mode word wrong");
    a_comm_word: assert property (
        @(posedge i_link_clk) disable iff (!i_nrst)
        o_reg.wr && o_reg.sel == SEL_COMM |-> o_reg.wdata == COMM_TX)
        else $error("comm word wrong");
    a_div_floor: assert property (
        @(posedge i_link_clk) disable iff (!i_nrst)
        o_reg.wr && o_reg.sel == SEL_DATA
            |-> o_reg.wdata[15:9] >= DIV_MIN_FAST && !o_reg.wdata[8])
        else $error("data word divider below floor");
    a_read_status: assert property (
        @(posedge i_link_clk) disable iff (!i_nrst)
        o_reg.rd |-> o_reg.sel == SEL_STATUS && !o_reg.wr)
        else $error("read of other than status");
    a_stop_pulse: assert property (
        @(posedge i_link_clk) disable iff (!i_nrst)
        o_stop_req |=> !o_stop_req && !o_reg.wr)
        else $error("stop request not a single pulse");
    c_refused: cover property (@(posedge i_clk) o_refused);
    c_ack_err: cover property (@(posedge i_clk) o_done && o_ack_err);
    c_data_wr: cover property (@(posedge i_link_clk)
        o_reg.wr && o_reg.sel == SEL_DATA);
endmodule // i2c_tx_ctrl_sva

bind i2c_tx_ctrl i2c_tx_ctrl_sva chk (.i_clk, .i_nrst, .i_link_clk, .i_cfg,
    .i_go, .i_addr_sent, .i_byte_valid, .i_byte, .o_byte_ready, .o_busy,
    .o_done, .o_ack_err, .o_refused, .o_reg, .i_reg_rdata, .i_xfer_end,
    .o_stop_req);

// >>> testbench/i2c_dev_model.sv
// behavioural model of the serial channel seen through its registers
`timescale 1ns/100ps
module i2c_dev_model
    import i2c_tx_ctrl_pkg::*;
(
    input  wire logic                      i_link_clk,
    input  wire logic                      i_nrst,
    input  wire i2c_tx_ctrl_pkg::reg_cmd_t i_reg,
    input  wire logic [31:0]               i_nack_at,
    input  wire logic [31:0]               i_delay,
    output logic [15:0]                    o_rdata,
    output logic                           o_xfer_end
);
    logic [15:0] mode_w, comm_w, status;
    logic [6:0]  div_w;
    logic [7:0]  log_b [0:63];
    logic [8:0]  frame;
    logic        first_bit;
    logic        sda_lvl;
    int          n_bytes, n_bad, cnt, hold;
    always @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {mode_w, comm_w, status, div_w} <= '0;
            {n_bytes, n_bad, cnt, hold} <= '0;
            frame <= '1;
            first_bit <= 1'b0;
            o_xfer_end <= 1'b0;
        end else begin
            if (i_reg.wr) begin
                case (i_reg.sel)
                    SEL_MODE: mode_w <= i_reg.wdata;
                    SEL_COMM: comm_w <= i_reg.wdata;
                    SEL_DATA: begin
                        log_b[n_bytes] <= i_reg.wdata[7:0];
                        div_w <= i_reg.wdata[15:9];
                        n_bytes <= n_bytes + 1;
                        cnt <= i_delay;
                        frame <= {i_reg.wdata[7:0], 1'b1};
                    end
                    default: n_bad <= n_bad + 1;
                endcase
            end
            if (cnt != 0) begin
                cnt <= cnt - 1;
                frame <= {frame[7:0], 1'b1};
                if (cnt == i_delay) first_bit <= frame[8];
                if (cnt == 1) o_xfer_end <= ~o_xfer_end;
            end
            // ack error the only status bit
            if (i_reg.rd) begin
                hold <= 6;
                status <= {14'h0000, n_bytes == i_nack_at, 1'b0};
            end else if (hold != 0) hold <= hold - 1;
        end
    end
    // released bus shows the inverse, never a stale copy
    assign o_rdata = (hold != 0) ? status : ~status;
    // level bit follows the line, idle high
    assign sda_lvl = frame[8];
endmodule // i2c_dev_model

// >>> testbench/tb.sv
// self-checking bench for the i2c data-send controller
`timescale 1ns/100ps
module tb;
    import i2c_tx_ctrl_pkg::*;
    logic        i_clk, i_nrst, i_link_clk, i_go, i_addr_sent, i_byte_valid;
    logic        o_byte_ready, o_busy, o_done, o_ack_err, o_refused;
    logic        o_stop_req, i_xfer_end;
    logic [15:0] i_reg_rdata;
    xfer_cfg_t   i_cfg;
    tx_byte_t    i_byte;
    reg_cmd_t    o_reg;
    int          n_mismatch, compares, nack_at, delay;
    int          stops = 0;
    i2c_tx_ctrl uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_link_clk(i_link_clk),
        .i_cfg(i_cfg), .i_go(i_go), .i_addr_sent(i_addr_sent),
        .i_byte_valid(i_byte_valid), .i_byte(i_byte),
        .o_byte_ready(o_byte_ready), .o_busy(o_busy), .o_done(o_done),
        .o_ack_err(o_ack_err), .o_refused(o_refused), .o_reg(o_reg),
        .i_reg_rdata(i_reg_rdata), .i_xfer_end(i_xfer_end),
        .o_stop_req(o_stop_req));
    i2c_dev_model dev (.i_link_clk(i_link_clk), .i_nrst(i_nrst), .i_reg(o_reg),
        .i_nack_at(nack_at), .i_delay(delay), .o_rdata(i_reg_rdata),
        .o_xfer_end(i_xfer_end));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        i_link_clk = 1'b0;
        #7;
        forever #32 i_link_clk = ~i_link_clk;
    end
    always @(posedge i_link_clk) if (o_stop_req === 1'b1) stops <= stops + 1;
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [7:0] byte_of(int k);
        return 8'(8'h3c + 8'h29 * k);
    endfunction
    task automatic t_refuse();
        @(posedge i_clk) #1 i_addr_sent = 1'b0;
        i_go = 1'b1;
        @(posedge i_clk) #1 i_go = 1'b0;
        i_addr_sent = 1'b1;
        check("refused", {15'h0, o_refused}, 16'h0001);
        check("busy", {15'h0, o_busy}, 16'h0000);
    endtask
    task automatic t_run(logic [6:0] dv, logic fs, int nb, int nk,
                         logic [6:0] edv);
        int k, base, st, sent;
        logic [7:0] lb;
        base = dev.n_bytes;
        st = stops;
        sent = (nk == 0) ? nb : nk;
        lb = byte_of(sent - 1);
        nack_at = (nk == 0) ? 0 : base + nk;
        i_cfg = '{dv, 1'b1, fs};
        for (k = 0; k < nb; k++) begin
            @(posedge i_clk) #1 i_byte_valid = 1'b1;
            i_byte = '{k == nb - 1, byte_of(k)};
        end
        if (nb == 16) begin
            // extra byte offered to a full fifo must be dropped
            @(posedge i_clk) #1 i_byte = '{1'b1, 8'hee};
            check("full", {15'h0, o_byte_ready}, 16'h0000);
        end
        @(posedge i_clk) #1 i_byte_valid = 1'b0;
        i_go = 1'b1;
        @(posedge i_clk) #1 i_go = 1'b0;
        check("busy", {15'h0, o_busy}, 16'h0001);
        for (k = 0; k < 20000 && o_done !== 1'b1; k++) @(posedge i_clk) #1;
        check("done", {15'h0, o_done}, 16'h0001);
        check("ack_err", {15'h0, o_ack_err}, 16'(nk != 0));
        check("bytes", 16'(dev.n_bytes - base), 16'(sent));
        for (k = 0; k < sent; k++)
            check("byte", dev.log_b[base + k], byte_of(k));
        check("div", dev.div_w, edv);
        check("mode", dev.mode_w, MODE_FIXED | 16'h8000);
        check("comm", dev.comm_w, COMM_TX);
        check("locked", 16'(dev.n_bad), 16'h0000);
        check("stop", 16'(stops - st), 16'h0001);
        check("idle", {15'h0, dev.sda_lvl}, 16'h0001);
        check("msb", {15'h0, dev.first_bit}, {15'h0, lb[7]});
    endtask
    initial begin
        {i_go, i_byte_valid, i_nrst} = '0;
        i_addr_sent = 1'b1;
        i_cfg = '0;
        i_byte = '0;
        {n_mismatch, compares, nack_at} = '0;
        delay = 20;
        repeat (6) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 check("ready", {15'h0, o_byte_ready}, 16'h0001);
        t_refuse();
        t_run(7'h00, 1'b0, 3, 0, 7'd124);
        t_run(7'h05, 1'b1, 2, 0, 7'd31);
        t_run(7'd100, 1'b1, 1, 0, 7'd100);
        delay = 60;
        t_run(7'h00, 1'b1, 16, 0, 7'd31);
        delay = 20;
        t_run(7'd40, 1'b1, 3, 2, 7'd40);
        end_of_test();
    end
    initial begin
        #(40 * 60000);
        n_mismatch++;
        end_of_test();
    end
endmodule // tb
